// ---- sdram_cke_bank_command_fsm.sv ----
`timescale 1ns/1ps
module sdram_cke_bank_command_fsm #(
	parameter int NUM_BANKS = 4,
	parameter int PRECHARGE_CYCLES = sdram_cmd_pkg::PRECHARGE_CYC,
	parameter int ACTIVATE_CYCLES = sdram_cmd_pkg::ACT_CYC,
	parameter int REFRESH_CYCLES = sdram_cmd_pkg::REFRESH_CYC,
	parameter int MODE_CYCLES = sdram_cmd_pkg::MODE_SET_DELAY_CYC,
	parameter int SR_EXIT_CYCLES = sdram_cmd_pkg::SR_EXIT_CYC,
	parameter int BURST_LENGTH = sdram_cmd_pkg::BURST_LEN
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic gate,
	input wire sdram_cmd_pkg::cmd_bus_s cmdBus,
	output sdram_cmd_pkg::cmd_e cmdDecoded,
	output sdram_cmd_pkg::dev_e devState,
	output logic [3*NUM_BANKS-1:0] bankStates,
	output logic allIdle,
	output logic burstActive,
	output logic [1:0] burstBank
);
	localparam int CW = sdram_cmd_pkg::CNT_W;

	initial begin
		if (NUM_BANKS != 4 || PRECHARGE_CYCLES < 1 || ACTIVATE_CYCLES < 1 ||
				REFRESH_CYCLES < 1 || MODE_CYCLES < 1 || SR_EXIT_CYCLES < 2 ||
				BURST_LENGTH < 1 || REFRESH_CYCLES >= (1 << CW) ||
				SR_EXIT_CYCLES >= (1 << CW) || BURST_LENGTH >= (1 << CW)) begin
			$error("sdram_cke_bank_command_fsm: unsupported parameters");
		end
	end

	sdram_cmd_pkg::cmd_e cmd;
	sdram_cmd_pkg::bank_e bankState [NUM_BANKS];
	logic [CW-1:0] bankCnt [NUM_BANKS];
	logic gatePrev;
	logic [CW-1:0] devCnt;
	logic [CW-1:0] burstCnt;
	logic frozen;
	logic allBanksIdle;
	logic autoPre;
	logic precAll;

	// command decode from the four strobes
	always_comb begin
		if (cmdBus.csN) begin
			cmd = sdram_cmd_pkg::CMD_INHIBIT;
		end else begin
			case ({cmdBus.rasN, cmdBus.casN, cmdBus.weN})
				3'h7: cmd = sdram_cmd_pkg::CMD_NOP;
				3'h3: cmd = sdram_cmd_pkg::CMD_ACTIVATE;
				3'h1: cmd = sdram_cmd_pkg::CMD_REFRESH;
				3'h0: cmd = sdram_cmd_pkg::CMD_LOAD_MODE;
				3'h2: cmd = sdram_cmd_pkg::CMD_PRECHARGE;
				3'h5: cmd = sdram_cmd_pkg::CMD_READ;
				3'h4: cmd = sdram_cmd_pkg::CMD_WRITE;
				3'h6: cmd = sdram_cmd_pkg::CMD_BURST_STOP;
				default: cmd = sdram_cmd_pkg::CMD_RESERVED;
			endcase
		end
	end

	logic isNop;
	assign isNop = (cmd == sdram_cmd_pkg::CMD_INHIBIT) || (cmd == sdram_cmd_pkg::CMD_NOP);
	assign autoPre = cmdBus.addr[sdram_cmd_pkg::AUTO_PRECHARGE_BIT];
	assign precAll = cmdBus.addr[sdram_cmd_pkg::AUTO_PRECHARGE_BIT];

	always_comb begin
		allBanksIdle = 1'b1;
		for (int i = 0; i < NUM_BANKS; i++) begin
			if (bankState[i] != sdram_cmd_pkg::BANK_IDLE) begin
				allBanksIdle = 1'b0;
			end
		end
	end

	// commands act on banks only in normal operation with the gate high both edges
	logic execute;
	assign execute = (devState == sdram_cmd_pkg::DEV_ACTIVE) && gatePrev && gate;
	// the internal clock is frozen while suspended or on the suspending edge
	assign frozen = (devState == sdram_cmd_pkg::DEV_SUSPEND) ||
		(devState == sdram_cmd_pkg::DEV_ACTIVE && gatePrev && !gate && burstActive);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			gatePrev <= 1'b1;
		end else if (clkEn) begin
			gatePrev <= gate;
		end
	end

	// device level state machine
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			devState <= sdram_cmd_pkg::DEV_ACTIVE;
			devCnt <= '0;
		end else if (clkEn) begin
			case (devState)
				sdram_cmd_pkg::DEV_ACTIVE: begin
					if (gatePrev && !gate) begin
						if (burstActive) begin
							devState <= sdram_cmd_pkg::DEV_SUSPEND;
						end else if (allBanksIdle && cmd == sdram_cmd_pkg::CMD_REFRESH) begin
							devState <= sdram_cmd_pkg::DEV_SELF_REFRESH;
						end else if (isNop) begin
							devState <= sdram_cmd_pkg::DEV_POWER_DOWN;
						end
					end else if (execute) begin
						if (cmd == sdram_cmd_pkg::CMD_REFRESH) begin
							devState <= sdram_cmd_pkg::DEV_REFRESHING;
							devCnt <= CW'(REFRESH_CYCLES - 1);
						end else if (cmd == sdram_cmd_pkg::CMD_LOAD_MODE) begin
							devState <= sdram_cmd_pkg::DEV_MODE_ACCESS;
							devCnt <= CW'(MODE_CYCLES - 1);
						end else if (cmd == sdram_cmd_pkg::CMD_PRECHARGE && precAll) begin
							devState <= sdram_cmd_pkg::DEV_PRECHARGE_ALL;
							devCnt <= CW'(PRECHARGE_CYCLES - 1);
						end
					end
				end
				sdram_cmd_pkg::DEV_POWER_DOWN: begin
					if (gate && isNop) begin
						devState <= sdram_cmd_pkg::DEV_ACTIVE;
					end
				end
				sdram_cmd_pkg::DEV_SELF_REFRESH: begin
					if (gate && isNop) begin
						devState <= sdram_cmd_pkg::DEV_SR_EXIT;
						devCnt <= CW'(SR_EXIT_CYCLES - 1);
					end
				end
				sdram_cmd_pkg::DEV_SUSPEND: begin
					if (gate) begin
						devState <= sdram_cmd_pkg::DEV_ACTIVE;
					end
				end
				default: begin
					// timed transients ignore commands until their count runs out
					if (devCnt == '0) begin
						devState <= sdram_cmd_pkg::DEV_ACTIVE;
					end else begin
						devCnt <= devCnt - CW'(1);
					end
				end
			endcase
		end
	end

	// burst tracking; stop acts on the most recent burst, any bank
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			burstActive <= 1'b0;
			burstBank <= 2'h0;
			burstCnt <= '0;
		end else if (clkEn && !frozen) begin
			if (execute && (cmd == sdram_cmd_pkg::CMD_READ || cmd == sdram_cmd_pkg::CMD_WRITE)) begin
				burstActive <= 1'b1;
				burstBank <= cmdBus.bank;
				burstCnt <= CW'(BURST_LENGTH - 1);
			end else if (execute && cmd == sdram_cmd_pkg::CMD_BURST_STOP) begin
				burstActive <= 1'b0;
			end else if (execute && cmd == sdram_cmd_pkg::CMD_PRECHARGE &&
					(precAll || cmdBus.bank == burstBank)) begin
				burstActive <= 1'b0;
			end else if (burstActive) begin
				if (burstCnt == '0) begin
					burstActive <= 1'b0;
				end else begin
					burstCnt <= burstCnt - CW'(1);
				end
			end
		end
	end

	// per-bank state machines
	genvar b;
	generate
		for (b = 0; b < NUM_BANKS; b++) begin : g_bank
			logic hit;
			logic burstEnds;
			assign hit = execute && (cmdBus.bank == 2'(b));
			assign burstEnds = burstActive && burstBank == 2'(b) && !frozen &&
				((execute && cmd == sdram_cmd_pkg::CMD_BURST_STOP) || burstCnt == '0 ||
				(execute && (cmd == sdram_cmd_pkg::CMD_READ || cmd == sdram_cmd_pkg::CMD_WRITE) &&
				cmdBus.bank != 2'(b)));
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					bankState[b] <= sdram_cmd_pkg::BANK_IDLE;
					bankCnt[b] <= '0;
				end else if (clkEn && !frozen) begin
					case (bankState[b])
						sdram_cmd_pkg::BANK_IDLE: begin
							if (hit && cmd == sdram_cmd_pkg::CMD_ACTIVATE) begin
								bankState[b] <= sdram_cmd_pkg::BANK_ACTIVATING;
								bankCnt[b] <= CW'(ACTIVATE_CYCLES - 1);
							end
						end
						sdram_cmd_pkg::BANK_ACTIVATING: begin
							if (bankCnt[b] == '0) begin
								bankState[b] <= sdram_cmd_pkg::BANK_ROW_ACTIVE;
							end else begin
								bankCnt[b] <= bankCnt[b] - CW'(1);
							end
						end
						sdram_cmd_pkg::BANK_PRECHARGING, sdram_cmd_pkg::BANK_READ_AP,
						sdram_cmd_pkg::BANK_WRITE_AP: begin
							if (bankCnt[b] == '0) begin
								bankState[b] <= sdram_cmd_pkg::BANK_IDLE;
							end else begin
								bankCnt[b] <= bankCnt[b] - CW'(1);
							end
						end
						default: begin
							// row active, read or write without auto precharge
							if (execute && cmd == sdram_cmd_pkg::CMD_PRECHARGE && (precAll || hit)) begin
								bankState[b] <= sdram_cmd_pkg::BANK_PRECHARGING;
								bankCnt[b] <= CW'(PRECHARGE_CYCLES - 1);
							end else if (hit && cmd == sdram_cmd_pkg::CMD_READ) begin
								bankState[b] <= autoPre ? sdram_cmd_pkg::BANK_READ_AP :
									sdram_cmd_pkg::BANK_READ;
								bankCnt[b] <= CW'(BURST_LENGTH + PRECHARGE_CYCLES - 1);
							end else if (hit && cmd == sdram_cmd_pkg::CMD_WRITE) begin
								bankState[b] <= autoPre ? sdram_cmd_pkg::BANK_WRITE_AP :
									sdram_cmd_pkg::BANK_WRITE;
								bankCnt[b] <= CW'(BURST_LENGTH + PRECHARGE_CYCLES - 1);
							end else if (burstEnds && bankState[b] != sdram_cmd_pkg::BANK_ROW_ACTIVE) begin
								bankState[b] <= sdram_cmd_pkg::BANK_ROW_ACTIVE;
							end
						end
					endcase
				end
			end
			assign bankStates[3*b +: 3] = bankState[b];
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cmdDecoded <= sdram_cmd_pkg::CMD_INHIBIT;
		end else if (clkEn) begin
			cmdDecoded <= frozen ? sdram_cmd_pkg::CMD_INHIBIT : cmd;
		end
	end

	assign allIdle = allBanksIdle && (devState == sdram_cmd_pkg::DEV_ACTIVE);
endmodule : sdram_cke_bank_command_fsm

// ---- sdram_cke_bank_command_fsm_tb_top.sv ----
`timescale 1ns/1ps
module sdram_cke_bank_command_fsm_tb_top;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic clkEn = 1'h1;
	logic gate = 1'h1;
	logic ap = 1'h0;
	logic [1:0] bank = 2'h0;
	sdram_cmd_pkg::cmd_e op = sdram_cmd_pkg::CMD_NOP;
	sdram_cmd_pkg::cmd_bus_s cmdBus;
	sdram_cmd_pkg::cmd_e cmdDecoded;
	sdram_cmd_pkg::dev_e devState;
	logic [11:0] bankStates;
	logic allIdle;
	logic burstActive;
	logic [1:0] burstBank;
	int errors = 0;
	int checks_done = 0;
	int cycles = 0;
	sdram_ctrl_model sdram_ctrl_model_inst (.op(op), .bank(bank), .ap(ap), .cmdBus(cmdBus));
	sdram_cke_bank_command_fsm sdram_cke_bank_command_fsm_inst (.clk(clk), .rst_n(rst_n),
		.clkEn(clkEn), .gate(gate), .cmdBus(cmdBus), .cmdDecoded(cmdDecoded),
		.devState(devState), .bankStates(bankStates), .allIdle(allIdle),
		.burstActive(burstActive), .burstBank(burstBank));
	initial forever #5 clk = ~clk;
	task automatic give_verdict;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : give_verdict
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			give_verdict();
		end
	end
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	function automatic logic [2:0] bs(input int b);
		return bankStates[3*b +: 3];
	endfunction : bs
	// one command for one edge, then back to nop
	task automatic go(input sdram_cmd_pkg::cmd_e o = sdram_cmd_pkg::CMD_NOP,
		input logic [1:0] b = 2'h0, input logic a = 1'h0);
		op = o;
		bank = b;
		ap = a;
		@(posedge clk);
		#1;
		op = sdram_cmd_pkg::CMD_NOP;
	endtask : go
	// b below zero watches the device state; only nops are sent meanwhile
	task automatic waitFor(input int b, input logic [2:0] t);
		for (int i = 0; i < 10 && (b < 0 ? devState : bs(b)) !== t; i++) go();
		check(b < 0 ? devState : bs(b), t);
	endtask : waitFor
	task automatic tBank;
		go(sdram_cmd_pkg::CMD_ACTIVATE, 2'h1);
		check(cmdDecoded, sdram_cmd_pkg::CMD_ACTIVATE);
		check(bs(1), sdram_cmd_pkg::BANK_ACTIVATING);
		waitFor(1, sdram_cmd_pkg::BANK_ROW_ACTIVE);
		go(sdram_cmd_pkg::CMD_ACTIVATE, 2'h2);
		waitFor(2, sdram_cmd_pkg::BANK_ROW_ACTIVE);
		go(sdram_cmd_pkg::CMD_READ, 2'h1);
		check(bs(1), sdram_cmd_pkg::BANK_READ);
		go(sdram_cmd_pkg::CMD_INHIBIT);
		check(burstActive, 1'h1);
		go(sdram_cmd_pkg::CMD_WRITE, 2'h2);
		check(burstBank, 2'h2);
		go(sdram_cmd_pkg::CMD_READ, 2'h2);
		check(bs(2), sdram_cmd_pkg::BANK_READ);
		go(sdram_cmd_pkg::CMD_BURST_STOP, 2'h0);
		check(burstActive, 1'h0);
		check(bs(2), sdram_cmd_pkg::BANK_ROW_ACTIVE);
		go(sdram_cmd_pkg::CMD_PRECHARGE, 2'h3);
		check(bs(3), sdram_cmd_pkg::BANK_IDLE);
		go(sdram_cmd_pkg::CMD_READ, 2'h1);
		go(sdram_cmd_pkg::CMD_PRECHARGE, 2'h1);
		check(bs(1), sdram_cmd_pkg::BANK_PRECHARGING);
		waitFor(1, sdram_cmd_pkg::BANK_IDLE);
		go(sdram_cmd_pkg::CMD_READ, 2'h2, 1'h1);
		check(bs(2), sdram_cmd_pkg::BANK_READ_AP);
		waitFor(2, sdram_cmd_pkg::BANK_IDLE);
	endtask : tBank
	// issued only with every bank idle and nops in between
	task automatic tDev;
		check(allIdle, 1'h1);
		go(sdram_cmd_pkg::CMD_REFRESH);
		check(devState, sdram_cmd_pkg::DEV_REFRESHING);
		check(allIdle, 1'h0);
		waitFor(-1, sdram_cmd_pkg::DEV_ACTIVE);
		go(sdram_cmd_pkg::CMD_LOAD_MODE);
		check(devState, sdram_cmd_pkg::DEV_MODE_ACCESS);
		waitFor(-1, sdram_cmd_pkg::DEV_ACTIVE);
		go(sdram_cmd_pkg::CMD_PRECHARGE, 2'h0, 1'h1);
		check(devState, sdram_cmd_pkg::DEV_PRECHARGE_ALL);
		waitFor(-1, sdram_cmd_pkg::DEV_ACTIVE);
	endtask : tDev
	task automatic tLow(input sdram_cmd_pkg::cmd_e o, input logic [2:0] st, input logic [2:0] ex);
		gate = 1'h0;
		go(o);
		check(devState, st);
		go(sdram_cmd_pkg::CMD_ACTIVATE, 2'h1);
		check(devState, st);
		check(bs(1), sdram_cmd_pkg::BANK_IDLE);
		gate = 1'h1;
		go();
		check(devState, ex);
		waitFor(-1, sdram_cmd_pkg::DEV_ACTIVE);
	endtask : tLow
	task automatic tSusp;
		go(sdram_cmd_pkg::CMD_ACTIVATE, 2'h0);
		waitFor(0, sdram_cmd_pkg::BANK_ROW_ACTIVE);
		go(sdram_cmd_pkg::CMD_READ, 2'h0);
		gate = 1'h0;
		go(sdram_cmd_pkg::CMD_PRECHARGE, 2'h0);
		check(devState, sdram_cmd_pkg::DEV_SUSPEND);
		check(cmdDecoded, sdram_cmd_pkg::CMD_INHIBIT);
		go(sdram_cmd_pkg::CMD_PRECHARGE, 2'h0);
		check(bs(0), sdram_cmd_pkg::BANK_READ);
		gate = 1'h1;
		go(sdram_cmd_pkg::CMD_BURST_STOP);
		check(devState, sdram_cmd_pkg::DEV_ACTIVE);
		go(sdram_cmd_pkg::CMD_PRECHARGE, 2'h0);
		check(bs(0), sdram_cmd_pkg::BANK_PRECHARGING);
		waitFor(0, sdram_cmd_pkg::BANK_IDLE);
	endtask : tSusp
	initial begin
		repeat (8) @(posedge clk);
		#1;
		rst_n = 1'h1;
		go();
		tBank();
		tDev();
		tLow(sdram_cmd_pkg::CMD_NOP, sdram_cmd_pkg::DEV_POWER_DOWN, sdram_cmd_pkg::DEV_ACTIVE);
		tLow(sdram_cmd_pkg::CMD_REFRESH, sdram_cmd_pkg::DEV_SELF_REFRESH,
			sdram_cmd_pkg::DEV_SR_EXIT);
		tSusp();
		give_verdict();
	end
endmodule : sdram_cke_bank_command_fsm_tb_top

// ---- sdram_cmd_pkg.sv ----
package sdram_cmd_pkg;
	// timing figures in ns (the mode set delay given directly in cycles) and the cycle counts derived at 100 MHz
	localparam int CLK_PERIOD_NS = 10;
	localparam int PRECHARGE_PERIOD_NS = 20;
	localparam int ACTIVATE_TO_COLUMN_DELAY_NS = 20;
	localparam int REFRESH_CYCLE_TIME_NS = 70;
	localparam int MODE_SET_DELAY_CYC = 2;
	localparam int SELF_REFRESH_EXIT_DELAY_NS = 70;
	localparam int PRECHARGE_CYC = (PRECHARGE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACT_CYC = (ACTIVATE_TO_COLUMN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REFRESH_CYC = (REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SR_EXIT_CYC = (SELF_REFRESH_EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BURST_LEN = 4;
	localparam int CNT_W = 8;
	localparam int AUTO_PRECHARGE_BIT = 10;

	typedef enum logic [3:0] {
		CMD_INHIBIT, CMD_NOP, CMD_ACTIVATE, CMD_REFRESH, CMD_LOAD_MODE,
		CMD_PRECHARGE, CMD_READ, CMD_WRITE, CMD_BURST_STOP, CMD_RESERVED
	} cmd_e;

	typedef enum logic [2:0] {
		DEV_ACTIVE, DEV_POWER_DOWN, DEV_SELF_REFRESH, DEV_SR_EXIT, DEV_SUSPEND,
		DEV_REFRESHING, DEV_MODE_ACCESS, DEV_PRECHARGE_ALL
	} dev_e;

	typedef enum logic [2:0] {
		BANK_IDLE, BANK_ACTIVATING, BANK_ROW_ACTIVE, BANK_READ, BANK_WRITE,
		BANK_READ_AP, BANK_WRITE_AP, BANK_PRECHARGING
	} bank_e;

	typedef struct packed {
		logic csN;
		logic rasN;
		logic casN;
		logic weN;
		logic [1:0] bank;
		logic [10:0] addr;
	} cmd_bus_s;
endpackage : sdram_cmd_pkg

// ---- sdram_ctrl_model.sv ----
`timescale 1ns/1ps
// controller side: turns a requested command into the strobe pattern
module sdram_ctrl_model (
	input wire sdram_cmd_pkg::cmd_e op,
	input wire logic [1:0] bank,
	input wire logic ap,
	output sdram_cmd_pkg::cmd_bus_s cmdBus
);
	logic [3:0] pins;
	always_comb begin
		case (op)
			sdram_cmd_pkg::CMD_NOP: pins = 4'h7;
			sdram_cmd_pkg::CMD_ACTIVATE: pins = 4'h3;
			sdram_cmd_pkg::CMD_REFRESH: pins = 4'h1;
			sdram_cmd_pkg::CMD_LOAD_MODE: pins = 4'h0;
			sdram_cmd_pkg::CMD_PRECHARGE: pins = 4'h2;
			sdram_cmd_pkg::CMD_READ: pins = 4'h5;
			sdram_cmd_pkg::CMD_WRITE: pins = 4'h4;
			sdram_cmd_pkg::CMD_BURST_STOP: pins = 4'h6;
			// inhibit leaves strobes at the worst pattern
			default: pins = 4'h8;
		endcase
		cmdBus = {pins, bank, ap, 10'h155};
	end
endmodule : sdram_ctrl_model

// ---- sdram_fsm_sva.sv ----
`timescale 1ns/1ps
module sdram_fsm_sva #(
	parameter int NUM_BANKS = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic gate,
	input wire sdram_cmd_pkg::cmd_bus_s cmdBus,
	input wire sdram_cmd_pkg::cmd_e cmdDecoded,
	input wire sdram_cmd_pkg::dev_e devState,
	input wire logic [3*NUM_BANKS-1:0] bankStates,
	input wire logic allIdle,
	input wire logic burstActive,
	input wire logic [1:0] burstBank
);
	logic [3:0] pins;
	logic nopish;
	logic live;
	assign pins = {cmdBus.csN, cmdBus.rasN, cmdBus.casN, cmdBus.weN};
	assign nopish = pins[3] || pins == 4'h7;
	assign live = clkEn && gate && devState == sdram_cmd_pkg::DEV_ACTIVE;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence sr_leave;
		devState == sdram_cmd_pkg::DEV_SR_EXIT ##[1:8] devState == sdram_cmd_pkg::DEV_ACTIVE;
	endsequence
	sequence refresh_done;
		##[1:8] devState == sdram_cmd_pkg::DEV_ACTIVE;
	endsequence
	chk_hold_low_power: assert property (clkEn && !gate && !$past(gate) && devState inside
		{sdram_cmd_pkg::DEV_POWER_DOWN, sdram_cmd_pkg::DEV_SELF_REFRESH,
		sdram_cmd_pkg::DEV_SUSPEND} |=> $stable(devState)) else $error("low power state left");
	chk_pd_exit: assert property (clkEn && gate && nopish
		&& devState == sdram_cmd_pkg::DEV_POWER_DOWN |=> devState == sdram_cmd_pkg::DEV_ACTIVE)
		else $error("power-down exit late");
	chk_sr_exit_wait: assert property (clkEn && gate && nopish
		&& devState == sdram_cmd_pkg::DEV_SELF_REFRESH |=> sr_leave) else $error("sr exit wrong");
	chk_suspend_exit: assert property (clkEn && gate
		&& devState == sdram_cmd_pkg::DEV_SUSPEND |=> devState == sdram_cmd_pkg::DEV_ACTIVE)
		else $error("suspend exit late");
	chk_pd_entry: assert property (clkEn && !gate && $past(gate) && allIdle && nopish
		|=> devState == sdram_cmd_pkg::DEV_POWER_DOWN) else $error("no power-down entry");
	chk_suspend_entry: assert property (clkEn && !gate && $past(gate) && burstActive
		&& devState == sdram_cmd_pkg::DEV_ACTIVE |=> devState == sdram_cmd_pkg::DEV_SUSPEND
		&& $stable(burstBank)) else $error("no suspend entry");
	chk_sr_entry: assert property (clkEn && !gate && $past(gate) && allIdle && pins == 4'h1
		|=> devState == sdram_cmd_pkg::DEV_SELF_REFRESH) else $error("no self refresh entry");
	chk_read_decode: assert property (live && pins == 4'h5
		|=> cmdDecoded == sdram_cmd_pkg::CMD_READ) else $error("read not decoded");
	chk_idle_precharge: assert property (live && pins == 4'h2 && !cmdBus.addr[10]
		&& bankStates[3*cmdBus.bank +: 3] == sdram_cmd_pkg::BANK_IDLE
		|=> bankStates[3*$past(cmdBus.bank) +: 3] == sdram_cmd_pkg::BANK_IDLE)
		else $error("idle bank disturbed");
	chk_stop_recent: assert property (live && pins == 4'h6 && burstActive
		|=> !burstActive) else $error("burst not stopped");
	chk_refresh_ends: assert property (clkEn
		&& devState == sdram_cmd_pkg::DEV_REFRESHING |-> refresh_done) else $error("refresh hangs");
endmodule : sdram_fsm_sva

bind sdram_cke_bank_command_fsm sdram_fsm_sva #(.NUM_BANKS(NUM_BANKS)) sdram_fsm_sva_inst (
	.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .gate(gate), .cmdBus(cmdBus),
	.cmdDecoded(cmdDecoded), .devState(devState), .bankStates(bankStates),
	.allIdle(allIdle), .burstActive(burstActive), .burstBank(burstBank));
